// *** hw/watchdog_and_reset_cause.sv ***
// Watchdog timers (one basic, two multi-counter) and the retained reset-cause register.
// Assumes the oscillator clocks are slow level inputs synchronous to clk and that
// the reset request output drives the device-wide reset controller.
// Notes on behaviour
// - Basic watchdog has one free 16-bit counter
// - Multi watchdogs: two 16-bit, one 32-bit, modes
// - Every 16-bit counter can request device reset
// - Every counter raises interrupt on match
// - Basic watchdog counts low-speed oscillator only
// - Basic watchdog runs through all low modes
// - Multi watchdogs use selectable low-frequency clock
// - Multi watchdogs run except in hibernate
// - Active-low external pin resets device
// - Firmware can request reset on demand
// - Hibernate wake-up issues device reset
// - Resets act asynchronously to known state
// - Retained register records reset cause
`timescale 1ns/1ps
module watchdog_and_reset_cause #(
  parameter int NUM_MWDT = 2
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic external_reset_pin_n,
  // Oscillators, sampled as ticks
  input wire logic low_speed_internal_osc,
  input wire logic watch_crystal_osc,
  input wire logic low_freq_clock_sel_crystal,
  // System mode
  input wire wdt_pkg::sys_mode_t sys_mode,
  input wire logic hibernate_wake,
  // Basic watchdog control
  input wire logic basic_en,
  input wire logic basic_reset_en,
  input wire logic basic_service,
  input wire logic [15:0] basic_match,
  // Multi-counter watchdog control, software reset request and cause clear
  input wire wdt_pkg::mwdt_cfg_t [1:0] mwdt_cfg,
  input wire logic [1:0] mwdt_service,
  input wire logic sw_reset_req,
  input wire logic cause_clear,
  // Results
  output logic basic_irq,
  output wdt_pkg::mwdt_evt_t [1:0] mwdt_evt,
  output logic device_reset_req,
  output logic [wdt_pkg::CAUSE_W-1:0] reset_cause
);
  logic slow_q, slow_d, lfsel_q, lfsel_d;
  logic slow_tick, lf_tick;
  logic [15:0] bcnt_q, bcnt_d;
  logic basic_irq_q, basic_irq_d, basic_rst;
  logic [1:0][15:0] c16_q [2];
  logic [1:0][15:0] c16_d [2];
  logic [31:0] c32_q [2];
  logic [31:0] c32_d [2];
  wdt_pkg::mwdt_evt_t [1:0] evt_q, evt_d;
  logic [wdt_pkg::CAUSE_W-1:0] cause_q, cause_d;
  logic [wdt_pkg::CAUSE_W-1:0] src;
  logic mwdt_run;

  // Edge detect of the slow oscillators; the 20 MHz clock oversamples them
  always_comb begin
    slow_d = low_speed_internal_osc;
    lfsel_d = low_freq_clock_sel_crystal ? watch_crystal_osc : low_speed_internal_osc;
  end
  assign slow_tick = low_speed_internal_osc & ~slow_q;
  assign lf_tick = lfsel_d & ~lfsel_q;
  // Hibernate stops the multi watchdogs but not the basic one
  assign mwdt_run = (sys_mode != wdt_pkg::MODE_HIBERNATE);

  // Basic watchdog: counts in every mode, service restarts the interval
  always_comb begin
    bcnt_d = bcnt_q;
    basic_irq_d = 1'b0;
    basic_rst = 1'b0;
    if (basic_service) begin
      bcnt_d = 16'h0000;
    end else if (basic_en && slow_tick) begin
      bcnt_d = bcnt_q + 16'h0001;
      if (bcnt_q == basic_match) begin
        basic_irq_d = 1'b1;
        basic_rst = basic_reset_en;
      end
    end
  end

  // Multi-counter watchdogs
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      c16_d[i] = c16_q[i];
      c32_d[i] = c32_q[i];
      evt_d[i] = '0;
      for (int k = 0; k < 2; k++) begin
        if (mwdt_service[i] && mwdt_cfg[i].reset_en[k]) begin
          c16_d[i][k] = 16'h0000;
        end else if (mwdt_cfg[i].en16[k] && lf_tick && mwdt_run &&
                     (k == 0 || !mwdt_cfg[i].cascade || evt_d[i].irq[0])) begin
          c16_d[i][k] = c16_q[i][k] + 16'h0001;
          if (c16_q[i][k] == (k == 0 ? mwdt_cfg[i].match0 : mwdt_cfg[i].match1)) begin
            evt_d[i].irq[k] = 1'b1;
            if (mwdt_cfg[i].reset_en[k]) begin
              evt_d[i].reset_req = 1'b1;
            end
            if (mwdt_cfg[i].clear_on_match[k]) begin
              c16_d[i][k] = 16'h0000;
            end
          end
        end
      end
      if (mwdt_cfg[i].en32 && lf_tick && mwdt_run &&
          (!mwdt_cfg[i].cascade || evt_d[i].irq[1])) begin
        c32_d[i] = c32_q[i] + 32'h00000001;
        if (c32_q[i] == mwdt_cfg[i].match2) begin
          evt_d[i].irq[2] = 1'b1;
        end
      end
    end
  end

  // Reset sources; the cause register sits on por_n only so it survives them
  always_comb begin
    src = '0;
    src[wdt_pkg::CAUSE_PIN] = ~external_reset_pin_n;
    src[wdt_pkg::CAUSE_SW] = sw_reset_req;
    src[wdt_pkg::CAUSE_BWDT] = basic_rst;
    src[wdt_pkg::CAUSE_MWDT0] = evt_d[0].reset_req;
    src[wdt_pkg::CAUSE_MWDT1] = evt_d[1].reset_req;
    src[wdt_pkg::CAUSE_HIB] = hibernate_wake && (sys_mode == wdt_pkg::MODE_HIBERNATE);
    // New causes win over a clear in the same cycle
    cause_d = (cause_clear ? '0 : cause_q) | src;
  end

  // The pin also resets combinationally, so it acts without a clock edge
  assign device_reset_req = ~external_reset_pin_n | (|src);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_q <= 1'b0;
      lfsel_q <= 1'b0;
      bcnt_q <= 16'h0000;
      basic_irq_q <= 1'b0;
      c16_q[0] <= '0;
      c16_q[1] <= '0;
      c32_q[0] <= '0;
      c32_q[1] <= '0;
      evt_q <= '0;
    end else begin
      slow_q <= slow_d;
      lfsel_q <= lfsel_d;
      bcnt_q <= bcnt_d;
      basic_irq_q <= basic_irq_d;
      c16_q <= c16_d;
      c32_q <= c32_d;
      evt_q <= evt_d;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      cause_q <= wdt_pkg::CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  assign basic_irq = basic_irq_q;
  assign mwdt_evt = evt_q;
  assign reset_cause = cause_q;

  // Checks
  AST_BASIC_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    (basic_en && !basic_service && slow_tick && bcnt_q == basic_match) |=> basic_irq)
    else $error("basic match without interrupt");
  AST_BASIC_RST: assert property (@(posedge clk) disable iff (!rst_n)
    (basic_en && basic_reset_en && !basic_service && slow_tick && bcnt_q == basic_match)
    |-> device_reset_req)
    else $error("basic timeout without reset request");
  AST_SERVICE: assert property (@(posedge clk) disable iff (!rst_n)
    basic_service |=> bcnt_q == 16'h0000)
    else $error("service did not restart basic counter");
  AST_BASIC_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (!basic_service && !slow_tick) |=> $stable(bcnt_q))
    else $error("basic counter moved without tick");
  AST_MWDT_HIB: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_mode == wdt_pkg::MODE_HIBERNATE && mwdt_service == 2'b00) |=> $stable(c32_q[0]))
    else $error("multi watchdog ran in hibernate");
  AST_PIN: assert property (@(posedge clk) disable iff (!por_n)
    !external_reset_pin_n |-> device_reset_req ##1 reset_cause[wdt_pkg::CAUSE_PIN])
    else $error("pin reset not requested or recorded");
  AST_SW: assert property (@(posedge clk) disable iff (!por_n)
    sw_reset_req |-> device_reset_req ##1 reset_cause[wdt_pkg::CAUSE_SW])
    else $error("software reset not requested or recorded");
  AST_CAUSE_SET_WINS: assert property (@(posedge clk) disable iff (!por_n)
    (cause_clear && src != '0) |=> (reset_cause == $past(src)))
    else $error("cause lost on clear");
  AST_HIB_WAKE: assert property (@(posedge clk) disable iff (!por_n)
    (hibernate_wake && sys_mode == wdt_pkg::MODE_HIBERNATE) |-> device_reset_req)
    else $error("hibernate wake gave no reset");

  // Basic watchdog
  AST_BASIC_NO_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    !(basic_en && !basic_service && slow_tick && bcnt_q == basic_match)
    |=> !basic_irq)
    else $error("basic interrupt without match");
  AST_BASIC_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    (basic_en && !basic_service && slow_tick)
    |=> bcnt_q == $past(bcnt_q) + 16'h0001)
    else $error("basic counter did not step on tick");
  AST_BASIC_NO_RST: assert property (@(posedge clk) disable iff (!rst_n)
    !basic_reset_en
    |-> !basic_rst)
    else $error("basic reset while reset disabled");
  AST_BASIC_HIB: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_mode == wdt_pkg::MODE_HIBERNATE && basic_en && !basic_service && slow_tick)
    |=> bcnt_q != $past(bcnt_q))
    else $error("basic watchdog stopped in hibernate");
  AST_BASIC_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    (!low_speed_internal_osc && !basic_service)
    |=> $stable(bcnt_q))
    else $error("basic counter moved without its oscillator");
  AST_BASIC_CAUSE: assert property (@(posedge clk) disable iff (!por_n)
    basic_rst
    |=> reset_cause[wdt_pkg::CAUSE_BWDT])
    else $error("basic timeout not recorded");

  // Multi-counter watchdogs
  AST_MWDT0_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    (mwdt_cfg[0].en16[0] && lf_tick && mwdt_run && !(mwdt_service[0] && mwdt_cfg[0].reset_en[0])
     && c16_q[0][0] == mwdt_cfg[0].match0)
    |=> mwdt_evt[0].irq[0])
    else $error("multi watchdog 0 match without interrupt");
  AST_MWDT1_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    (mwdt_cfg[1].en16[0] && lf_tick && mwdt_run && !(mwdt_service[1] && mwdt_cfg[1].reset_en[0])
     && c16_q[1][0] == mwdt_cfg[1].match0)
    |=> mwdt_evt[1].irq[0])
    else $error("multi watchdog 1 match without interrupt");
  AST_MWDT0_RST: assert property (@(posedge clk) disable iff (!rst_n)
    evt_d[0].reset_req
    |-> device_reset_req)
    else $error("multi watchdog 0 timeout without reset request");
  AST_MWDT1_RST: assert property (@(posedge clk) disable iff (!rst_n)
    evt_d[1].reset_req
    |-> device_reset_req)
    else $error("multi watchdog 1 timeout without reset request");
  AST_MWDT0_SERVICE: assert property (@(posedge clk) disable iff (!rst_n)
    (mwdt_service[0] && mwdt_cfg[0].reset_en[0])
    |=> c16_q[0][0] == 16'h0000)
    else $error("service did not restart multi counter");
  AST_MWDT1_SERVICE: assert property (@(posedge clk) disable iff (!rst_n)
    (mwdt_service[1] && mwdt_cfg[1].reset_en[1])
    |=> c16_q[1][1] == 16'h0000)
    else $error("service did not restart multi counter");
  AST_MWDT_C32: assert property (@(posedge clk) disable iff (!rst_n)
    (mwdt_cfg[1].en32 && !mwdt_cfg[1].cascade && lf_tick && mwdt_run)
    |=> c32_q[1] == $past(c32_q[1]) + 32'h00000001)
    else $error("wide counter did not step on tick");
  AST_MWDT_CASCADE: assert property (@(posedge clk) disable iff (!rst_n)
    (mwdt_cfg[1].cascade && !mwdt_service[1] && !evt_d[1].irq[0])
    |=> $stable(c16_q[1][1]))
    else $error("cascaded counter moved without lower match");
  AST_MWDT_CASCADE32: assert property (@(posedge clk) disable iff (!rst_n)
    (mwdt_cfg[1].cascade && !evt_d[1].irq[1])
    |=> $stable(c32_q[1]))
    else $error("cascaded wide counter moved without lower match");
  AST_MWDT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (evt_d[0].irq[0] && mwdt_cfg[0].clear_on_match[0])
    |=> c16_q[0][0] == 16'h0000)
    else $error("clear on match did not clear");
  AST_MWDT_HIB1: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_mode == wdt_pkg::MODE_HIBERNATE && mwdt_service == 2'b00)
    |=> $stable(c16_q[1]))
    else $error("multi watchdog ran in hibernate");
  AST_MWDT_HIB_EVT: assert property (@(posedge clk) disable iff (!rst_n)
    sys_mode == wdt_pkg::MODE_HIBERNATE
    |=> mwdt_evt == '0)
    else $error("multi watchdog event in hibernate");
  AST_LF_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
    lf_tick
    |-> (low_freq_clock_sel_crystal ? watch_crystal_osc : low_speed_internal_osc))
    else $error("multi watchdog ticked from unselected oscillator");

  // Reset sources and cause register
  AST_CAUSE_STICKY: assert property (@(posedge clk) disable iff (!por_n)
    !cause_clear
    |=> (reset_cause & $past(reset_cause)) == $past(reset_cause))
    else $error("cause bit lost without clear");
  AST_CAUSE_CLEAR: assert property (@(posedge clk) disable iff (!por_n)
    (cause_clear && src == '0)
    |=> reset_cause == '0)
    else $error("cause not cleared");
  AST_IDLE: assert property (@(posedge clk) disable iff (!por_n)
    (src == '0 && external_reset_pin_n)
    |-> !device_reset_req)
    else $error("reset request without source");
  AST_MWDT_CAUSE1: assert property (@(posedge clk) disable iff (!por_n)
    evt_d[1].reset_req
    |=> reset_cause[wdt_pkg::CAUSE_MWDT1])
    else $error("multi watchdog 1 timeout not recorded");
  AST_HIB_CAUSE: assert property (@(posedge clk) disable iff (!por_n)
    (hibernate_wake && sys_mode == wdt_pkg::MODE_HIBERNATE)
    |=> reset_cause[wdt_pkg::CAUSE_HIB])
    else $error("hibernate wake not recorded");

  COV_BASIC_TIMEOUT: cover property (@(posedge clk) disable iff (!rst_n) basic_rst);
  COV_CASCADE: cover property (@(posedge clk) disable iff (!rst_n) mwdt_evt[1].irq[2]);
  COV_MWDT_SERVICE: cover property (@(posedge clk) disable iff (!rst_n) mwdt_service[1]);
  COV_MWDT_IRQ32: cover property (@(posedge clk) disable iff (!rst_n) mwdt_evt[0].irq[2]);
  COV_MWDT_RST: cover property (@(posedge clk) disable iff (!rst_n) mwdt_evt[1].reset_req);
endmodule // watchdog_and_reset_cause

// *** hw/wdt_pkg.sv ***
// Shared constants and carrier types for the watchdog and reset-cause block.
// Assumes a single 20 MHz system clock; the slow oscillators arrive as level inputs.
package wdt_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CNT16_W = 16;
  localparam int CNT32_W = 32;
  localparam int CAUSE_W = 6;
  // Reset cause bit positions
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_SW = 1;
  localparam int CAUSE_BWDT = 2;
  localparam int CAUSE_MWDT0 = 3;
  localparam int CAUSE_MWDT1 = 4;
  localparam int CAUSE_HIB = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h00;
  localparam logic [15:0] MATCH16_RST = 16'hFFFF;
  localparam logic [31:0] MATCH32_RST = 32'hFFFFFFFF;

  typedef enum logic [3:0] {
    MODE_ACTIVE = 4'h1,
    MODE_ULTRA_LOW = 4'h2,
    MODE_DEEP_SLEEP = 4'h4,
    MODE_HIBERNATE = 4'h8
  } sys_mode_t;

  // Configuration of one multi-counter watchdog
  typedef struct packed {
    logic [1:0] en16;
    logic en32;
    logic [1:0] reset_en;
    logic [1:0] clear_on_match;
    logic cascade;
    logic [15:0] match0;
    logic [15:0] match1;
    logic [31:0] match2;
  } mwdt_cfg_t;

  // Events of one multi-counter watchdog
  typedef struct packed {
    logic [2:0] irq;
    logic reset_req;
  } mwdt_evt_t;
endpackage

// *** sim/testbench.sv ***
// Self-checking bench for the watchdog and reset-cause block.
// Assumes the design from hw/; oscillator ticks are made as slow levels in clk cycles.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0, por_n = 1'b0, ext_n = 1'b1, lso = 1'b0, xtal = 1'b0, sel_x = 1'b0;
  logic ev_clr = 1'b0;
  logic [3:0] ev1 = 4'h0;
  logic hib_wake = 1'b0, basic_en = 1'b0, basic_reset_en = 1'b0, basic_service = 1'b0;
  logic sw_reset_req = 1'b0, cause_clear = 1'b0;
  logic [15:0] basic_match = 16'h0000;
  logic [1:0] mwdt_service = 2'h0;
  wdt_pkg::sys_mode_t sys_mode = wdt_pkg::MODE_ACTIVE;
  wdt_pkg::mwdt_cfg_t [1:0] mwdt_cfg = '0;
  wdt_pkg::mwdt_evt_t [1:0] mwdt_evt;
  logic basic_irq, device_reset_req;
  logic [wdt_pkg::CAUSE_W-1:0] reset_cause;
  int errors = 0, n_tests = 0, nb = 0, nm = 0, cyc = 0, b0, m0;

  always #25 clk = ~clk;

  watchdog_and_reset_cause dut (.clk(clk), .rst_n(rst_n), .por_n(por_n),
    .external_reset_pin_n(ext_n), .low_speed_internal_osc(lso), .watch_crystal_osc(xtal),
    .low_freq_clock_sel_crystal(sel_x), .sys_mode(sys_mode), .hibernate_wake(hib_wake),
    .basic_en(basic_en), .basic_reset_en(basic_reset_en), .basic_service(basic_service),
    .basic_match(basic_match), .mwdt_cfg(mwdt_cfg), .mwdt_service(mwdt_service),
    .sw_reset_req(sw_reset_req), .cause_clear(cause_clear), .basic_irq(basic_irq),
    .mwdt_evt(mwdt_evt), .device_reset_req(device_reset_req), .reset_cause(reset_cause));

  // Pulse counters let scenarios judge irqs without racing the one-cycle pulse
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (basic_irq === 1'b1) nb <= nb + 1;
    if (mwdt_evt[0].irq[0] === 1'b1) nm <= nm + 1;
    // Sticky capture of the second watchdog's one-cycle events
    if (ev_clr) ev1 <= 4'h0;
    else ev1 <= ev1 | mwdt_evt[1];
    if (cyc == 3000) begin
      errors = errors + 1;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(input bit use_x);
    @(negedge clk);
    if (use_x) xtal = 1'b1;
    else lso = 1'b1;
    @(negedge clk);
    xtal = 1'b0;
    lso = 1'b0;
    @(negedge clk);
  endtask

  task automatic do_reset(input bit por);
    @(negedge clk);
    rst_n = 1'b0;
    if (por) por_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    @(negedge clk);
  endtask

  task automatic scen_basic();
    do_reset(1);
    chk("cause after power-on", 32'h0, reset_cause);
    chk("reset request idle", 32'h0, device_reset_req);
    sys_mode = wdt_pkg::MODE_DEEP_SLEEP;
    basic_en = 1'b1;
    basic_reset_en = 1'b1;
    basic_match = 16'h0002;
    b0 = nb;
    repeat (2) tick(0);
    @(negedge clk) basic_service = 1'b1;
    @(negedge clk) basic_service = 1'b0;
    repeat (2) tick(0);
    chk("basic irq after service", 32'h0, nb - b0);
    tick(0);
    chk("basic irq on match", 32'h1, nb - b0);
    chk("basic cause", 32'h1, reset_cause[wdt_pkg::CAUSE_BWDT]);
    basic_en = 1'b0;
    sys_mode = wdt_pkg::MODE_ACTIVE;
  endtask

  task automatic scen_multi();
    do_reset(1);
    sel_x = 1'b1;
    mwdt_cfg[0].en16 = 2'b01;
    mwdt_cfg[0].reset_en = 2'b01;
    mwdt_cfg[0].match0 = 16'h0001;
    m0 = nm;
    repeat (2) tick(0);
    chk("multi irq from unselected osc", 32'h0, nm - m0);
    repeat (2) tick(1);
    chk("multi irq on match", 32'h1, nm - m0);
    chk("multi cause", 32'h1, reset_cause[wdt_pkg::CAUSE_MWDT0]);
    do_reset(0);
    sys_mode = wdt_pkg::MODE_HIBERNATE;
    m0 = nm;
    repeat (3) tick(1);
    chk("multi irq in hibernate", 32'h0, nm - m0);
    sys_mode = wdt_pkg::MODE_ACTIVE;
    mwdt_cfg = '0;
  endtask

  task automatic ev_reset();
    ev_clr = 1'b1;
    @(negedge clk) ev_clr = 1'b0;
  endtask

  // All matches at zero: one tick ripples through the whole cascade
  task automatic scen_cascade();
    do_reset(1);
    sel_x = 1'b0;
    mwdt_cfg[1].en16 = 2'b11;
    mwdt_cfg[1].en32 = 1'b1;
    mwdt_cfg[1].cascade = 1'b1;
    mwdt_cfg[1].clear_on_match = 2'b01;
    mwdt_cfg[1].reset_en = 2'b10;
    ev_reset();
    tick(0);
    chk("cascade first tick events", 32'hF, ev1);
    chk("multi 1 cause", 32'h1, reset_cause[wdt_pkg::CAUSE_MWDT1]);
    ev_reset();
    tick(0);
    chk("cascade second tick events", 32'h2, ev1);
    @(negedge clk) mwdt_service = 2'b10;
    @(negedge clk) mwdt_service = 2'b00;
    ev_reset();
    tick(0);
    chk("cascade events after service", 32'h7, ev1);
    mwdt_cfg = '0;
  endtask

  task automatic scen_causes();
    do_reset(1);
    @(negedge clk) sw_reset_req = 1'b1;
    @(negedge clk) sw_reset_req = 1'b0;
    chk("software cause", 32'h1 << wdt_pkg::CAUSE_SW, reset_cause);
    @(negedge clk) ext_n = 1'b0;
    #1 chk("pin reset request", 32'h1, device_reset_req);
    @(negedge clk) ext_n = 1'b1;
    do_reset(0);
    chk("cause kept", 32'h3, reset_cause);
    sys_mode = wdt_pkg::MODE_HIBERNATE;
    @(negedge clk) hib_wake = 1'b1;
    @(negedge clk) hib_wake = 1'b0;
    chk("hibernate wake cause", 32'h1, reset_cause[wdt_pkg::CAUSE_HIB]);
    sys_mode = wdt_pkg::MODE_ACTIVE;
    @(negedge clk) cause_clear = 1'b1;
    @(negedge clk) cause_clear = 1'b0;
    chk("cause cleared", 32'h0, reset_cause);
  endtask

  task automatic final_report();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    scen_basic();
    scen_multi();
    scen_cascade();
    scen_causes();
    final_report();
  end
endmodule // testbench
